/* File: verilog/ca_top.sv */
// Counter array: shared 16-bit time base, clock source selection, three
// capture/compare modules and the module two watchdog.
// Assumes pin inputs are asynchronous, timer0_ovf is a one-cycle pulse on clk,
// and the pin crossbar outside routes the module pins and the count input.
// Notes on behaviour
// - One 16-bit time base shared by three modules.
// - Counter clock chosen from six sources.
// - Each module selects one of seven modes.
// - Pulse width modulation in 8 or 16 bits.
// - Module two can serve as watchdog.
// - Watchdog enabled by itself after every reset.
// - Module pins and count input face crossbar.
`timescale 1ns/10ps
module ca_top import ca_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic cnt_run,
   input wire logic [2:0] clk_sel,
   input wire logic timer0_ovf,
   input wire logic external_count_input,
   input wire logic ext_osc_clk,
   input wire logic [CA_NMOD-1:0][2:0] mod_mode,
   input wire logic [CA_NMOD-1:0][CA_CNT_W-1:0] mod_cmp,
   input wire logic [CA_NMOD-1:0] cap_rise,
   input wire logic [CA_NMOD-1:0] cap_fall,
   input wire logic [CA_NMOD-1:0] mod_in,
   input wire logic wd_disable,
   input wire logic wd_kick,
   input wire logic [7:0] wd_limit,
   output logic [CA_CNT_W-1:0] cnt_value,
   output logic cnt_ovf,
   output logic [CA_NMOD-1:0] mod_out,
   output logic [CA_NMOD-1:0] mod_out_oe,
   output logic [CA_NMOD-1:0] mod_match,
   output logic [CA_NMOD-1:0][CA_CNT_W-1:0] cap_value,
   output logic [CA_NMOD-1:0] cap_strobe,
   output logic wd_active,
   output logic wd_reset
);
   logic [CA_CNT_W-1:0] cnt_q;
   logic ovf_q;
   logic [3:0] div12_q;
   logic [1:0] div4_q;
   logic [2:0] ext8_q;
   logic cin_s1_q, cin_s2_q, cin_prev_q;
   logic eo_s1_q, eo_s2_q, eo_prev_q;
   logic [CA_NMOD-1:0] in_s1_q, in_s2_q;
   logic wd_en_q, wd_armed_q, wd_reset_q;
   logic [CA_CNT_W-1:0] wd_ref_q;

   // Asynchronous pins pass two flops; only the second stage is read.
   always_ff @(posedge clk) begin
      if (rst) begin
         cin_s1_q <= 1'b0;
         cin_s2_q <= 1'b0;
         cin_prev_q <= 1'b0;
         eo_s1_q <= 1'b0;
         eo_s2_q <= 1'b0;
         eo_prev_q <= 1'b0;
         in_s1_q <= '0;
         in_s2_q <= '0;
      end else begin
         cin_s1_q <= external_count_input;
         cin_s2_q <= cin_s1_q;
         cin_prev_q <= cin_s2_q;
         eo_s1_q <= ext_osc_clk;
         eo_s2_q <= eo_s1_q;
         eo_prev_q <= eo_s2_q;
         in_s1_q <= mod_in;
         in_s2_q <= in_s1_q;
      end
   end

   wire cin_rise = cin_s2_q & ~cin_prev_q;
   wire eo_rise = eo_s2_q & ~eo_prev_q;
   wire div12_tick = (div12_q == CA_DIV12_LAST);
   wire div4_tick = (div4_q == CA_DIV4_LAST);
   wire ext8_tick = eo_rise && (ext8_q == CA_EXT8_LAST);

   // The dividers run free so that switching the source never stalls them.
   always_ff @(posedge clk) begin
      if (rst) begin
         div12_q <= 4'h0;
         div4_q <= 2'h0;
         ext8_q <= 3'h0;
      end else begin
         div12_q <= div12_tick ? 4'h0 : div12_q + 4'h1;
         div4_q <= div4_q + 2'h1;
         if (eo_rise) begin
            ext8_q <= ext8_q + 3'h1;
         end
      end
   end

   // An external oscillator must stay below a quarter of clk to be seen.
   wire src_tick = (clk_sel == CA_SEL_DIV12) ? div12_tick :
                   (clk_sel == CA_SEL_DIV4) ? div4_tick :
                   (clk_sel == CA_SEL_T0OVF) ? timer0_ovf :
                   (clk_sel == CA_SEL_CNTIN) ? cin_rise :
                   (clk_sel == CA_SEL_SYS) ? 1'b1 :
                   (clk_sel == CA_SEL_EXT8) ? ext8_tick : 1'b0;
   wire tick = cnt_run && src_tick;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= CA_CNT_ZERO;
         ovf_q <= 1'b0;
      end else begin
         if (tick) begin
            cnt_q <= cnt_q + CA_CNT_ONE;
         end
         ovf_q <= tick && (cnt_q == CA_CNT_ALL1);
      end
   end

   // Module two yields to the watchdog; its user mode has no effect meanwhile.
   genvar i;
   generate
      for (i = 0; i < CA_NMOD; i++) begin : g_mod
         wire ca_mode_t mode_eff = (i == CA_WD_MOD && wd_en_q) ? CA_MODE_OFF : ca_mode_t'(mod_mode[i]);
         ca_ccm u_ccm (
            .clk(clk),
            .rst(rst),
            .tick(tick),
            .cnt(cnt_q),
            .mode(mode_eff),
            .cmp(mod_cmp[i]),
            .cap_rise(cap_rise[i]),
            .cap_fall(cap_fall[i]),
            .pin_in(in_s2_q[i]),
            .pin_out(mod_out[i]),
            .pin_oe(mod_out_oe[i]),
            .match(mod_match[i]),
            .cap_value(cap_value[i]),
            .cap_strobe(cap_strobe[i])
         );
      end
   endgenerate

   // The watchdog reference is counter plus limit in the upper byte; a kick
   // in the cycle of the hit reloads it and suppresses the reset request.
   wire wd_hit = wd_en_q && wd_armed_q && tick && (cnt_q == wd_ref_q) && !wd_kick;

   always_ff @(posedge clk) begin
      if (rst) begin
         wd_en_q <= 1'b1;
         wd_armed_q <= 1'b0;
         wd_ref_q <= CA_CNT_ZERO;
         wd_reset_q <= 1'b0;
      end else begin
         if (wd_disable) begin
            wd_en_q <= 1'b0;
         end
         if (wd_kick || !wd_armed_q) begin
            wd_armed_q <= 1'b1;
            wd_ref_q <= cnt_q + {wd_limit, CA_BYTE_ZERO};
         end
         wd_reset_q <= wd_hit;
      end
   end

   assign cnt_value = cnt_q;
   assign cnt_ovf = ovf_q;
   assign wd_active = wd_en_q;
   assign wd_reset = wd_reset_q;

   property p_wrap;
      @(posedge clk) disable iff (rst) tick && (cnt_q == CA_CNT_ALL1) |=> (cnt_q == CA_CNT_ZERO) && cnt_ovf;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

   property p_hold;
      @(posedge clk) disable iff (rst) !tick |=> $stable(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without an event");

   property p_step;
      @(posedge clk) disable iff (rst) (clk_sel == CA_SEL_SYS) && cnt_run |=> cnt_q == $past(cnt_q) + CA_CNT_ONE;
   endproperty
   a_step: assert property (p_step) else $error("counter did not step on system clock");

   property p_div12;
      @(posedge clk) disable iff (rst) div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick;
   endproperty
   a_div12: assert property (p_div12) else $error("divide by twelve period wrong");

   property p_div4;
      @(posedge clk) disable iff (rst) div4_tick |=> !div4_tick [*3] ##1 div4_tick;
   endproperty
   a_div4: assert property (p_div4) else $error("divide by four period wrong");

   property p_wd_reset_on;
      @(posedge clk) $past(rst) && !rst |-> wd_active && !mod_out_oe[CA_WD_MOD];
   endproperty
   a_wd_reset_on: assert property (p_wd_reset_on) else $error("watchdog not enabled after reset");

   property p_wd_fire;
      @(posedge clk) disable iff (rst) wd_hit |=> wd_reset ##1 !wd_reset;
   endproperty
   a_wd_fire: assert property (p_wd_fire) else $error("watchdog reset request wrong");

   property p_wd_owns;
      @(posedge clk) disable iff (rst) wd_en_q && $past(wd_en_q) |-> !mod_out_oe[CA_WD_MOD] && !mod_match[CA_WD_MOD];
   endproperty
   a_wd_owns: assert property (p_wd_owns) else $error("module two active during watchdog");

   property p_ovf_pulse;
      @(posedge clk) disable iff (rst) cnt_ovf |=> !cnt_ovf;
   endproperty
   a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse longer than one cycle");

   property p_wd_kick;
      @(posedge clk) disable iff (rst) wd_kick |=> wd_ref_q == $past(cnt_q) + {$past(wd_limit), CA_BYTE_ZERO};
   endproperty
   a_wd_kick: assert property (p_wd_kick) else $error("kick did not reload the watchdog window");

   // Disable is one-way so that a runaway program cannot re-enable it by accident.
   property p_wd_off;
      @(posedge clk) disable iff (rst) wd_disable |=> !wd_active;
   endproperty
   a_wd_off: assert property (p_wd_off) else $error("watchdog still active after disable");

   c_wrap: cover property (@(posedge clk) disable iff (rst) tick && (cnt_q == CA_CNT_ALL1));
   c_wd_fire: cover property (@(posedge clk) disable iff (rst) wd_reset);
   c_ext8: cover property (@(posedge clk) disable iff (rst) (clk_sel == CA_SEL_EXT8) && tick);
   c_cnt_in: cover property (@(posedge clk) disable iff (rst) (clk_sel == CA_SEL_CNTIN) && tick);
endmodule : ca_top

/* File: include/ca_pkg.sv */
// Shared constants and types of the counter array: counter width, clock source
// codes, divider limits and the module operating modes.
// Assumes one system clock domain and a synchronous active-high reset.
package ca_pkg;
   localparam int CA_CNT_W = 16;
   localparam int CA_NMOD = 3;
   localparam int CA_WD_MOD = 2;

   // Clock source select codes.
   localparam logic [2:0] CA_SEL_DIV12 = 3'h0;
   localparam logic [2:0] CA_SEL_DIV4 = 3'h1;
   localparam logic [2:0] CA_SEL_T0OVF = 3'h2;
   localparam logic [2:0] CA_SEL_CNTIN = 3'h3;
   localparam logic [2:0] CA_SEL_SYS = 3'h4;
   localparam logic [2:0] CA_SEL_EXT8 = 3'h5;

   // Divider terminal counts: a divide by N counts 0 to N-1.
   localparam logic [3:0] CA_DIV12_LAST = 4'hb;
   localparam logic [1:0] CA_DIV4_LAST = 2'h3;
   localparam logic [2:0] CA_EXT8_LAST = 3'h7;

   localparam logic [CA_CNT_W-1:0] CA_CNT_ZERO = 16'h0000;
   localparam logic [CA_CNT_W-1:0] CA_CNT_ONE = 16'h0001;
   localparam logic [CA_CNT_W-1:0] CA_CNT_ALL1 = 16'hffff;
   localparam logic [7:0] CA_BYTE_ZERO = 8'h00;

   // Watchdog window limit constant; the reference is the counter plus wd_limit in the upper byte.
   localparam logic [7:0] CA_WD_LIMIT_RST = 8'hff;

   typedef enum logic [2:0] {
      CA_MODE_OFF = 3'h0,
      CA_MODE_CAPTURE = 3'h1,
      CA_MODE_SWTIMER = 3'h2,
      CA_MODE_HSOUT = 3'h3,
      CA_MODE_PWM8 = 3'h4,
      CA_MODE_PWM16 = 3'h5,
      CA_MODE_FREQ = 3'h6
   } ca_mode_t;
endpackage : ca_pkg

/* File: verilog/ca_ccm.sv */
// One capture/compare module of the counter array.
// Assumes a synchronised pin input and a one-cycle counter tick from the parent.
`timescale 1ns/10ps
module ca_ccm import ca_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic [CA_CNT_W-1:0] cnt,
   input wire ca_mode_t mode,
   input wire logic [CA_CNT_W-1:0] cmp,
   input wire logic cap_rise,
   input wire logic cap_fall,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic match,
   output logic [CA_CNT_W-1:0] cap_value,
   output logic cap_strobe
);
   logic in_prev_q;
   logic out_q, out_d;
   logic oe_q, match_q, strobe_q;
   logic [CA_CNT_W-1:0] cap_q;
   logic [7:0] fq_q;
   wire edge_rise = pin_in & ~in_prev_q;
   wire edge_fall = ~pin_in & in_prev_q;
   wire cap_hit = (mode == CA_MODE_CAPTURE) && ((edge_rise && cap_rise) || (edge_fall && cap_fall));
   wire hit16 = tick && (cnt == cmp);
   wire hit8 = tick && (cnt[7:0] == fq_q);
   wire drives = (mode == CA_MODE_HSOUT) || (mode == CA_MODE_PWM8) ||
                 (mode == CA_MODE_PWM16) || (mode == CA_MODE_FREQ);
   wire match_d = ((mode == CA_MODE_SWTIMER) || (mode == CA_MODE_HSOUT)) && hit16;

   always_comb begin
      unique case (mode)
         CA_MODE_OFF, CA_MODE_CAPTURE, CA_MODE_SWTIMER: out_d = 1'b0;
         CA_MODE_HSOUT: out_d = out_q ^ hit16;
         CA_MODE_PWM8: out_d = cnt[7:0] < cmp[7:0];
         CA_MODE_PWM16: out_d = cnt < cmp;
         CA_MODE_FREQ: out_d = out_q ^ hit8;
         default: out_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_prev_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
         match_q <= 1'b0;
         strobe_q <= 1'b0;
      end else begin
         in_prev_q <= pin_in;
         out_q <= out_d;
         oe_q <= drives;
         match_q <= match_d;
         strobe_q <= cap_hit;
      end
   end

   // The frequency step sits in the upper compare byte; the lower byte seeds
   // the first toggle point whenever the module is outside that mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         cap_q <= CA_CNT_ZERO;
         fq_q <= CA_BYTE_ZERO;
      end else begin
         if (cap_hit) begin
            cap_q <= cnt;
         end
         if (mode != CA_MODE_FREQ) begin
            fq_q <= cmp[7:0];
         end else if (hit8) begin
            fq_q <= fq_q + cmp[15:8];
         end
      end
   end

   assign pin_out = out_q;
   assign pin_oe = oe_q;
   assign match = match_q;
   assign cap_value = cap_q;
   assign cap_strobe = strobe_q;

   property p_capture;
      @(posedge clk) disable iff (rst) cap_hit |=> cap_strobe && (cap_value == $past(cnt));
   endproperty
   a_capture: assert property (p_capture) else $error("capture value or strobe wrong");

   property p_pwm16;
      @(posedge clk) disable iff (rst) (mode == CA_MODE_PWM16) |=> (pin_out == ($past(cnt) < $past(cmp)));
   endproperty
   a_pwm16: assert property (p_pwm16) else $error("16-bit pwm level wrong");

   property p_pwm8;
      @(posedge clk) disable iff (rst)
         (mode == CA_MODE_PWM8) |=> (pin_out == ($past(cnt[7:0]) < $past(cmp[7:0])));
   endproperty
   a_pwm8: assert property (p_pwm8) else $error("8-bit pwm level wrong");

   property p_hsout;
      @(posedge clk) disable iff (rst) (mode == CA_MODE_HSOUT) && hit16 |=> (pin_out != $past(pin_out)) && match;
   endproperty
   a_hsout: assert property (p_hsout) else $error("high speed output did not toggle");
endmodule : ca_ccm

/* File: dv/testbench.sv */
// Self-checking bench for the counter array top level.
// Assumes ca_pkg and the design files are compiled first; one 100 MHz clock.
`timescale 1ns/10ps
module testbench import ca_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cnt_run = 1'b1;
   logic [2:0] clk_sel = 3'h4;
   logic timer0_ovf = 1'b0;
   logic external_count_input = 1'b0;
   logic ext_osc_clk = 1'b0;
   logic [CA_NMOD-1:0][2:0] mod_mode = 9'h000;
   logic [CA_NMOD-1:0][CA_CNT_W-1:0] mod_cmp = 48'h0;
   logic [CA_NMOD-1:0] cap_rise = 3'h0;
   logic [CA_NMOD-1:0] cap_fall = 3'h0;
   logic [CA_NMOD-1:0] mod_in = 3'h0;
   logic wd_disable = 1'b0;
   logic wd_kick = 1'b0;
   logic [7:0] wd_limit = 8'h01;
   logic [CA_CNT_W-1:0] cnt_value;
   logic cnt_ovf;
   logic [CA_NMOD-1:0] mod_out;
   logic [CA_NMOD-1:0] mod_out_oe;
   logic [CA_NMOD-1:0] mod_match;
   logic [CA_NMOD-1:0][CA_CNT_W-1:0] cap_value;
   logic [CA_NMOD-1:0] cap_strobe;
   logic wd_active;
   logic wd_reset;
   int n_fail = 0;
   int checked = 0;
   int n_wdr = 0;

   ca_top ca_top_inst (.clk, .rst, .cnt_run, .clk_sel, .timer0_ovf, .external_count_input, .ext_osc_clk,
      .mod_mode, .mod_cmp, .cap_rise, .cap_fall, .mod_in, .wd_disable, .wd_kick, .wd_limit, .cnt_value,
      .cnt_ovf, .mod_out, .mod_out_oe, .mod_match, .cap_value, .cap_strobe, .wd_active, .wd_reset);

   initial begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      #1;
      if (wd_reset === 1'b1) n_wdr++;
   end

   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         n_fail++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask : chk

   // Sampling one step after the edge lets the design's updates land first.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic t_wd;
      int n;
      chk(wd_active === 1'b1 && wd_reset === 1'b0, "watchdog not on after reset");
      @(posedge clk) mod_mode[2] <= CA_MODE_HSOUT;
      cyc(3);
      chk(mod_out_oe[2] === 1'b0, "module two left its watchdog role");
      n = n_wdr;
      repeat (5) begin
         @(posedge clk) wd_kick <= 1'b1;
         @(posedge clk) wd_kick <= 1'b0;
         cyc(120);
      end
      chk(n_wdr == n, "reset request despite kicks");
      cyc(300);
      chk(n_wdr == n + 1, "expected one reset request");
      @(posedge clk) wd_disable <= 1'b1;
      @(posedge clk) wd_disable <= 1'b0;
      cyc(600);
      chk(wd_active === 1'b0 && n_wdr == n + 1, "disable ignored");
      @(posedge clk) rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      chk(wd_active === 1'b1 && cnt_value < 16'h0004, "watchdog not back after reset");
      @(posedge clk) wd_disable <= 1'b1;
      @(posedge clk) wd_disable <= 1'b0;
      $display("watchdog test done");
   endtask : t_wd

   task automatic t_src(input logic [2:0] sel, input logic run, input logic [2:0] w, input int n,
      input logic [15:0] exp);
      logic [15:0] c0;
      @(posedge clk) begin
         clk_sel <= sel;
         cnt_run <= run;
      end
      cyc(4);
      c0 = cnt_value;
      repeat (n) begin
         @(posedge clk) {ext_osc_clk, external_count_input, timer0_ovf} <= w;
         @(posedge clk) {ext_osc_clk, external_count_input, timer0_ovf} <= 3'h0;
         cyc(3);
      end
      cyc(n == 0 ? 48 : 6);
      chk(cnt_value - c0 === exp, "count over window");
      $display("source %0d run %0d done", sel, run);
   endtask : t_src

   task automatic t_oe;
      for (int m = 0; m < 8; m++) begin
         @(posedge clk) mod_mode[0] <= m[2:0];
         cyc(3);
         chk(mod_out_oe[0] === (m inside {3, 4, 5, 6}), "output enable per mode");
      end
      $display("mode enable test done");
   endtask : t_oe

   task automatic t_hs(input ca_mode_t md);
      logic [15:0] c;
      logic o;
      int k;
      @(posedge clk) begin
         clk_sel <= CA_SEL_SYS;
         cnt_run <= 1'b1;
      end
      cyc(2);
      c = cnt_value + 16'h0020;
      @(posedge clk) begin
         mod_mode[1] <= md;
         mod_cmp[1] <= c;
      end
      cyc(3);
      o = mod_out[1];
      k = 0;
      while (mod_match[1] !== 1'b1 && k < 60) begin
         cyc(1);
         k++;
      end
      chk(mod_match[1] === 1'b1 && cnt_value === c + 16'h0001, "match moment");
      chk(mod_out[1] === (md == CA_MODE_HSOUT ? ~o : o), "output after match");
      cyc(1);
      chk(mod_match[1] === 1'b0, "match longer than one cycle");
      $display("compare mode %0d done", md);
   endtask : t_hs

   task automatic t_cap;
      int k;
      @(posedge clk) begin
         mod_mode[0] <= CA_MODE_CAPTURE;
         cap_rise <= 3'h1;
      end
      cyc(4);
      @(posedge clk) mod_in <= 3'h1;
      k = 0;
      while (cap_strobe[0] !== 1'b1 && k < 8) begin
         cyc(1);
         k++;
      end
      chk(cap_strobe[0] === 1'b1 && cap_value[0] === cnt_value - 16'h0001, "captured count");
      @(posedge clk) mod_in <= 3'h0;
      k = 0;
      repeat (8) begin
         cyc(1);
         if (cap_strobe[0] !== 1'b0) k++;
      end
      chk(k == 0, "capture on a disabled edge");
      $display("capture test done");
   endtask : t_cap

   task automatic t_pwm(input ca_mode_t md, input int exp);
      int k;
      @(posedge clk) begin
         mod_mode[0] <= md;
         mod_cmp[0] <= 16'h0080;
      end
      cyc(300);
      k = 0;
      repeat (256) begin
         cyc(1);
         if (mod_out[0] === 1'b1) k++;
      end
      chk(k == exp && cnt_value > 16'h0100, "high time over 256 ticks");
      $display("pwm mode %0d done", md);
   endtask : t_pwm

   task automatic t_freq;
      int k;
      logic o;
      @(posedge clk) begin
         mod_mode[0] <= CA_MODE_FREQ;
         mod_cmp[0] <= 16'h1000;
      end
      cyc(300);
      o = mod_out[0];
      k = 0;
      repeat (256) begin
         cyc(1);
         if (mod_out[0] !== o) k++;
         o = mod_out[0];
      end
      chk(k == 16, "frequency output toggles over 256 ticks");
      $display("frequency test done");
   endtask : t_freq

   task automatic t_wrap;
      int k;
      k = 0;
      while (cnt_value !== CA_CNT_ALL1 && k < 70000) begin
         cyc(1);
         k++;
      end
      cyc(1);
      chk(cnt_value === CA_CNT_ZERO && cnt_ovf === 1'b1, "wrap to zero");
      cyc(1);
      chk(cnt_value === CA_CNT_ONE && cnt_ovf === 1'b0, "step after wrap");
      $display("wrap test done");
   endtask : t_wrap

   initial begin
      repeat (95000) @(posedge clk);
      n_fail++;
      summarize;
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      t_wd;
      t_src(CA_SEL_SYS, 1'b1, 3'h0, 0, 16'h0030);
      t_src(CA_SEL_SYS, 1'b0, 3'h0, 0, 16'h0000);
      t_src(CA_SEL_DIV12, 1'b1, 3'h0, 0, 16'h0004);
      t_src(CA_SEL_DIV4, 1'b1, 3'h0, 0, 16'h000c);
      t_src(3'h6, 1'b1, 3'h0, 0, 16'h0000);
      t_src(3'h7, 1'b1, 3'h0, 0, 16'h0000);
      t_src(CA_SEL_T0OVF, 1'b1, 3'h1, 5, 16'h0005);
      t_src(CA_SEL_CNTIN, 1'b1, 3'h2, 6, 16'h0006);
      t_src(CA_SEL_EXT8, 1'b1, 3'h4, 32, 16'h0004);
      t_oe;
      t_hs(CA_MODE_HSOUT);
      t_hs(CA_MODE_SWTIMER);
      t_cap;
      t_pwm(CA_MODE_PWM8, 128);
      t_pwm(CA_MODE_PWM16, 0);
      t_freq;
      t_wrap;
      summarize;
   end
endmodule : testbench
